// ### verilog/nsoc_element.sv
// Purpose: negative sequence overcurrent element with fixed and inverse time delays
// Assumes: settings written over a plain register port, phasor sets arrive at sample rate
// Notes:   with an inverse curve, operate time is evaluated for each magnitude that arrives while the divider is idle, timing runs on a 1 ms tick
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "nsoc_cfg.svh"
module nsoc_element
  import nsoc_pkg::*;
#(
  parameter int unsigned TICK_CYC = `NSOC_TICK_NS / `NSOC_CLK_NS
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  input  wire logic             phasor_valid_i,
  input  wire logic [2:0][15:0] phase_re_i,
  input  wire logic [2:0][15:0] phase_im_i,
  input  wire logic             disable_i,
  output logic                  start_o,
  output logic                  trip_o
);
  localparam logic [`NSOC_TICK_W-1:0] TICK_LAST = `NSOC_TICK_W'(TICK_CYC - 1);

  nsoc_elem_t s;
  nsoc_elem_t next_s;
  nsoc_seq_if nsq ();

  logic        active;
  logic        inverse;
  logic        fixed;
  logic        tick;
  logic [15:0] thr;
  logic [15:0] drop;

  nsoc_negseq u_seq (
    .clock_i        (clock_i),
    .rst_n_i        (rst_n_i),
    .phasor_valid_i (phasor_valid_i),
    .phase_re_i     (phase_re_i),
    .phase_im_i     (phase_im_i),
    .seq            (nsq)
  );

  function automatic logic [15:0] nsoc_clamp(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
    if (v < 32'(lo)) begin
      return lo;
    end else if (v > 32'(hi)) begin
      return hi;
    end
    return v[15:0];
  endfunction

  // one restoring division bit: {remainder, quotient}
  function automatic logic [71:0] nsoc_div_step(input logic [31:0] rem, input logic [39:0] quo,
                                                input logic [31:0] dvs);
    logic [32:0] t;
    t = {rem, quo[39]};
    if (t >= 33'(dvs)) begin
      return {32'(t - 33'(dvs)), quo[38:0], 1'b1};
    end
    return {t[31:0], quo[38:0], 1'b0};
  endfunction

  // log2 of a ratio above one, Q5.11 in, Q.16 out, with a parabolic mantissa fix
  function automatic logic [18:0] nsoc_log2(input logic [15:0] m);
    logic [2:0]  p;
    logic [15:0] nm;
    logic [14:0] f;
    logic [31:0] pr;
    p = 3'h0;
    for (int i = 11; i < 16; i++) begin
      if (m[i]) begin
        p = 3'(i - 11);
      end
    end
    nm = m << (3'h4 - p);
    f  = nm[14:0];
    pr = (32'(f) * (32'h0000_8000 - 32'(f))) >> 15;
    pr = (pr * `NSOC_LOG2_CORR_Q16) >> 15;
    return {p, 16'h0} + 19'({f, 1'b0}) + 19'(pr);
  endfunction

  // ratio to the power alpha, less one, in Q16.16
  function automatic logic [31:0] nsoc_den(input logic [15:0] m, input nsoc_alpha_t a);
    logic [31:0] sq;
    logic [31:0] x;
    sq = 32'(m) * 32'(m);
    // small exponent: e^x - 1 taken to second order, x = 0.02 ln(ratio)
    x  = (32'(nsoc_log2(m)) * `NSOC_LN2_X002_Q16) >> 16;
    case (a)
      NSOC_ALPHA_1: return {11'h0, m, 5'h0} - `NSOC_ONE_Q16;
      NSOC_ALPHA_2: return (sq >> 6) - `NSOC_ONE_Q16;
      default:      return x + ((x * x) >> 17);
    endcase
  endfunction

  always_comb begin
    nsoc_coef_t  coef;
    logic [71:0] step;
    logic [25:0] el;
    logic [31:0] q32;
    coef   = nsoc_coef(s.curve);
    step   = nsoc_div_step(s.rem, s.quo, s.dvs);
    el     = '0;
    q32    = '0;
    next_s = s;
    thr     = 16'(s.pct) * `NSOC_COUNTS_PCT;
    drop    = thr - thr / `NSOC_DROP_DIV;
    fixed   = s.curve == `NSOC_CURVE_FIXED;
    inverse = s.curve > `NSOC_CURVE_FIXED;
    active  = !disable_i && s.curve != `NSOC_CURVE_OFF;
    tick    = s.tick_cnt == TICK_LAST;
    next_s.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;
    next_s.rdata    = '0;

    if (reg_wr_i) begin
      case (reg_addr_i)
        `NSOC_ADDR_CURVE: begin
          // out-of-range selections are ignored rather than mapped to a curve
          if (reg_wdata_i <= 32'(`NSOC_CURVE_LAST)) begin
            next_s.curve = reg_wdata_i[3:0];
          end
        end
        `NSOC_ADDR_PICKUP: next_s.pct = 8'(nsoc_clamp(reg_wdata_i, `NSOC_PICKUP_MIN, `NSOC_PICKUP_MAX));
        `NSOC_ADDR_FIXDLY: next_s.fix_dly = nsoc_clamp(reg_wdata_i, `NSOC_DELAY_MIN, `NSOC_DELAY_MAX);
        `NSOC_ADDR_MINDLY: next_s.min_dly = nsoc_clamp(reg_wdata_i, `NSOC_DELAY_MIN, `NSOC_DELAY_MAX);
        `NSOC_ADDR_RSTDLY: next_s.rst_dly = nsoc_clamp(reg_wdata_i, `NSOC_DELAY_MIN, `NSOC_DELAY_MAX);
        `NSOC_ADDR_TSCALE: next_s.tscale = nsoc_clamp(reg_wdata_i, `NSOC_TSCALE_MIN, `NSOC_TSCALE_MAX);
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `NSOC_ADDR_CURVE:  next_s.rdata = 32'(s.curve);
        `NSOC_ADDR_PICKUP: next_s.rdata = 32'(s.pct);
        `NSOC_ADDR_FIXDLY: next_s.rdata = 32'(s.fix_dly);
        `NSOC_ADDR_MINDLY: next_s.rdata = 32'(s.min_dly);
        `NSOC_ADDR_RSTDLY: next_s.rdata = 32'(s.rst_dly);
        `NSOC_ADDR_TSCALE: next_s.rdata = 32'(s.tscale);
        `NSOC_ADDR_STATUS: begin
          next_s.rdata[`NSOC_STATUS_START] = s.start;
          next_s.rdata[`NSOC_STATUS_TRIP]  = s.trip;
        end
        `NSOC_ADDR_MAG:    next_s.rdata = 32'(s.mag);
        default:           next_s.rdata = '0;
      endcase
    end

    // the sequence magnitude is the only operating quantity
    if (nsq.valid) begin
      next_s.mag = nsq.mag;
      if (!s.start) begin
        next_s.start = nsq.mag > thr;
      end else begin
        next_s.start = nsq.mag >= drop;
      end
    end

    case (s.st)
      NSOC_IDLE: begin
        if (nsq.valid && inverse) begin
          next_s.rem  = '0;
          next_s.quo  = 40'({nsq.mag, 11'h0});
          next_s.dvs  = 32'(thr);
          next_s.dcnt = '0;
          next_s.st   = NSOC_RATIO;
        end
      end
      NSOC_RATIO: begin
        next_s.rem  = step[71:40];
        next_s.quo  = step[39:0];
        next_s.dcnt = s.dcnt + 6'h1;
        if (s.dcnt == `NSOC_DIV_LAST) begin
          // beyond twenty times pickup the curve is held flat
          next_s.m  = (step[39:0] > 40'(`NSOC_RATIO_CLAMP)) ? `NSOC_RATIO_CLAMP : step[15:0];
          next_s.st = NSOC_DEN;
        end
      end
      NSOC_DEN: begin
        if (s.m <= `NSOC_RATIO_ONE) begin
          next_s.req_ok = 1'b0;
          next_s.st     = NSOC_IDLE;
        end else begin
          next_s.rem  = '0;
          next_s.quo  = 40'({coef.k, 16'h0});
          next_s.dvs  = nsoc_den(s.m, coef.alpha);
          next_s.dcnt = '0;
          next_s.st   = NSOC_KDIV;
        end
      end
      NSOC_KDIV: begin
        next_s.rem  = step[71:40];
        next_s.quo  = step[39:0];
        next_s.dcnt = s.dcnt + 6'h1;
        if (s.dcnt == `NSOC_DIV_LAST) begin
          // a zero divisor saturates the quotient, so a ratio barely above one never trips
          q32 = (|step[39:32]) ? 32'hffff_ffff : step[31:0];
          next_s.req    = 49'((33'(q32) + 33'(coef.c)) * 49'(s.tscale));
          next_s.req_ok = 1'b1;
          next_s.st     = NSOC_IDLE;
        end
      end
      default: next_s.st = NSOC_IDLE;
    endcase

    if (!active) begin
      next_s.start   = 1'b0;
      next_s.trip    = 1'b0;
      next_s.elapsed = '0;
      next_s.rst_cnt = '0;
    end else if (tick) begin
      if (next_s.start) begin
        el = (s.elapsed == `NSOC_ELAPSED_MAX) ? s.elapsed : s.elapsed + 26'h1;
        next_s.elapsed = el;
        next_s.rst_cnt = '0;
        if (fixed) begin
          next_s.trip = s.trip | (el >= 26'(s.fix_dly));
        end else begin
          next_s.trip = s.trip | (s.req_ok && el >= 26'(s.min_dly)
                        && 49'(36'(el) * `NSOC_REQ_SCALE) >= s.req);
        end
      end else if (inverse) begin
        if (s.rst_cnt >= s.rst_dly) begin
          next_s.elapsed = '0;
        end else begin
          next_s.rst_cnt = s.rst_cnt + 16'h1;
        end
      end
    end
    // trip only stands beside start; fixed timing restarts at every dropout
    if (!next_s.start) begin
      next_s.trip = 1'b0;
      if (fixed) begin
        next_s.elapsed = '0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s         <= '0;
      s.curve   <= `NSOC_CURVE_RST;
      s.pct     <= `NSOC_PICKUP_RST;
      s.fix_dly <= `NSOC_DELAY_RST;
      s.min_dly <= `NSOC_DELAY_RST;
      s.rst_dly <= `NSOC_DELAY_RST;
      s.tscale  <= `NSOC_TSCALE_RST;
      s.st      <= NSOC_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_o = s.rdata;
  assign start_o     = s.start;
  assign trip_o      = s.trip;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence seq_sample_above;
    nsq.valid && active && !s.start && nsq.mag > thr;
  endsequence
  sequence seq_kdiv_begin;
    s.st == NSOC_KDIV && s.dcnt == 6'h0;
  endsequence

  a_pickup_rise : assert property (seq_sample_above |=> start_o)
    else $error("start missing after magnitude above pickup");
  a_pickup_quiet : assert property (nsq.valid && !s.start && nsq.mag <= thr |=> !start_o)
    else $error("start raised at or below pickup");
  a_dropout_band : assert property (nsq.valid && active && s.start && nsq.mag >= drop |=> start_o)
    else $error("start dropped above 95 percent of pickup");
  a_disable_clear : assert property (disable_i |=> !start_o && !trip_o)
    else $error("outputs active while disabled");
  a_off_clear : assert property (s.curve == `NSOC_CURVE_OFF |=> !start_o && !trip_o)
    else $error("outputs active with element off");
  a_trip_start : assert property (trip_o |-> start_o)
    else $error("trip without start");
  a_trip_tick : assert property ($rose(trip_o) |-> $past(tick))
    else $error("trip rose away from a tick");
  a_fixed_time : assert property ($rose(trip_o) && fixed |-> s.elapsed >= 26'(s.fix_dly) && s.elapsed != 26'h0)
    else $error("fixed delay trip too early");
  a_min_delay : assert property ($rose(trip_o) && inverse |-> s.elapsed >= 26'(s.min_dly))
    else $error("inverse trip before minimum delay");
  a_ratio_clamp : assert property (s.st == NSOC_DEN |-> s.m <= `NSOC_RATIO_CLAMP)
    else $error("ratio above twenty times pickup");
  a_kdiv_done : assert property (seq_kdiv_begin |-> ##40 (s.st == NSOC_IDLE && s.req_ok))
    else $error("operate time not ready 40 cycles after divide start");
  a_pickup_range : assert property (16'(s.pct) >= `NSOC_PICKUP_MIN && 16'(s.pct) <= `NSOC_PICKUP_MAX)
    else $error("pickup setting out of range");
  a_scale_range : assert property (s.tscale >= `NSOC_TSCALE_MIN && s.tscale <= `NSOC_TSCALE_MAX)
    else $error("time multiplier out of range");
  a_reset_hold : assert property (inverse && active && !s.start && !nsq.valid && tick
    && s.rst_cnt < s.rst_dly |=> s.elapsed == $past(s.elapsed))
    else $error("inverse timing cleared before reset delay");
endmodule

// ### inc/nsoc_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the negative sequence element
// Assumes: magnitudes count 100 per percent of rated current
// Notes:   included by the package, by the element and by the sequence calculator
`ifndef NSOC_CFG_SVH
`define NSOC_CFG_SVH
`define NSOC_ADDR_CURVE     8'h00
`define NSOC_ADDR_PICKUP    8'h04
`define NSOC_ADDR_FIXDLY    8'h08
`define NSOC_ADDR_MINDLY    8'h0c
`define NSOC_ADDR_RSTDLY    8'h10
`define NSOC_ADDR_TSCALE    8'h14
`define NSOC_ADDR_STATUS    8'h18
`define NSOC_ADDR_MAG       8'h1c
`define NSOC_STATUS_START   0
`define NSOC_STATUS_TRIP    1
`define NSOC_CURVE_OFF      4'h0
`define NSOC_CURVE_FIXED    4'h1
`define NSOC_CURVE_LAST     4'hc
`define NSOC_CURVE_RST      4'h1
`define NSOC_PICKUP_MIN     16'h0005
`define NSOC_PICKUP_MAX     16'h00c8
`define NSOC_PICKUP_RST     8'h32
`define NSOC_DELAY_MIN      16'h0000
`define NSOC_DELAY_MAX      16'hea60
`define NSOC_DELAY_RST      16'h0064
`define NSOC_TSCALE_MIN     16'h0064
`define NSOC_TSCALE_MAX     16'hea60
`define NSOC_TSCALE_RST     16'h0064
`define NSOC_COUNTS_PCT     16'h0064
`define NSOC_DROP_DIV       16'h0014
`define NSOC_RATIO_FRAC     11
`define NSOC_RATIO_ONE      16'h0800
`define NSOC_RATIO_CLAMP    16'ha000
`define NSOC_ONE_Q16        32'h0001_0000
`define NSOC_REQ_SCALE      36'h0_0000_03e8
`define NSOC_SQRT3_Q14      16'h6eda
`define NSOC_SIXTH_Q16      16'h2aab
`define NSOC_LN2_X002_Q16   32'h0000_038d
`define NSOC_LOG2_CORR_Q16  32'h0000_57bb
`define NSOC_TICK_NS        1000000
`define NSOC_CLK_NS         10
`define NSOC_TICK_W         20
`define NSOC_ELAPSED_MAX    26'h3ff_ffff
`define NSOC_DIV_LAST       6'h27
`define NSOC_SQRT_TOP       5'h10
`endif

// ### inc/nsoc_pkg.sv
// Purpose: types and curve table of the negative sequence element
// Assumes: k and c are held in units of 0.1 ms
// Notes:   alpha 0.02 curves are evaluated through a logarithm approximation
package nsoc_pkg;
`include "nsoc_cfg.svh"

  typedef enum logic [1:0] {NSOC_ALPHA_P02, NSOC_ALPHA_1, NSOC_ALPHA_2} nsoc_alpha_t;

  typedef struct packed {
    logic [20:0] k;
    logic [12:0] c;
    nsoc_alpha_t alpha;
  } nsoc_coef_t;

  typedef enum logic [1:0] {NSOC_IDLE, NSOC_RATIO, NSOC_DEN, NSOC_KDIV} nsoc_state_t;

  typedef struct packed {
    logic [3:0]             curve;
    logic [7:0]             pct;
    logic [15:0]            fix_dly;
    logic [15:0]            min_dly;
    logic [15:0]            rst_dly;
    logic [15:0]            tscale;
    logic [31:0]            rdata;
    logic                   start;
    logic                   trip;
    logic [15:0]            mag;
    logic [`NSOC_TICK_W-1:0] tick_cnt;
    logic [25:0]            elapsed;
    logic [15:0]            rst_cnt;
    logic [15:0]            m;
    logic [48:0]            req;
    logic                   req_ok;
    nsoc_state_t            st;
    logic [31:0]            rem;
    logic [39:0]            quo;
    logic [31:0]            dvs;
    logic [5:0]             dcnt;
  } nsoc_elem_t;

  typedef struct packed {
    logic        busy;
    logic [33:0] sq;
    logic [16:0] root;
    logic [4:0]  idx;
    logic        valid;
    logic [15:0] mag;
  } nsoc_seq_t;

  // curve codes 2..12 in order: four IEC curves, then seven ANSI curves
  function automatic nsoc_coef_t nsoc_coef(input logic [3:0] sel);
    case (sel)
      4'h2:    nsoc_coef = '{21'h00_0578, 13'h0000, NSOC_ALPHA_P02};
      4'h3:    nsoc_coef = '{21'h02_0f58, 13'h0000, NSOC_ALPHA_1};
      4'h4:    nsoc_coef = '{21'h0c_3500, 13'h0000, NSOC_ALPHA_2};
      4'h5:    nsoc_coef = '{21'h12_4f80, 13'h0000, NSOC_ALPHA_1};
      4'h6:    nsoc_coef = '{21'h00_0056, 13'h00b9, NSOC_ALPHA_P02};
      4'h7:    nsoc_coef = '{21'h00_0203, 13'h0474, NSOC_ALPHA_P02};
      4'h8:    nsoc_coef = '{21'h02_fe04, 13'h132e, NSOC_ALPHA_2};
      4'h9:    nsoc_coef = '{21'h04_4d90, 13'h04c1, NSOC_ALPHA_2};
      4'ha:    nsoc_coef = '{21'h00_035c, 13'h073a, NSOC_ALPHA_P02};
      4'hb:    nsoc_coef = '{21'h04_5b3c, 13'h1bd0, NSOC_ALPHA_2};
      4'hc:    nsoc_coef = '{21'h09_c6bc, 13'h09c4, NSOC_ALPHA_2};
      default: nsoc_coef = '{21'h00_0000, 13'h0000, NSOC_ALPHA_1};
    endcase
  endfunction
endpackage

// ### inc/nsoc_seq_if.sv
// Purpose: negative sequence magnitude from the sequence calculator to the element
// Assumes: valid is a one-cycle pulse, mag holds until the next pulse
// Notes:   one clock domain
`timescale 1ns/1ps
interface nsoc_seq_if;
  logic        valid;
  logic [15:0] mag;
  modport src (output valid, output mag);
  modport dst (input valid, input mag);
endinterface

// ### verilog/nsoc_negseq.sv
// Purpose: negative sequence RMS magnitude from the fundamental phasors of three phases
// Assumes: phasors are RMS scaled, 100 counts per percent of rated current
// Notes:   a phasor set offered while a root is in progress is dropped
`timescale 1ns/1ps
`include "nsoc_cfg.svh"
module nsoc_negseq
  import nsoc_pkg::*;
(
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             phasor_valid_i,
  input  wire logic [2:0][15:0] phase_re_i,
  input  wire logic [2:0][15:0] phase_im_i,
  nsoc_seq_if.src               seq
);
  nsoc_seq_t s;
  nsoc_seq_t next_s;

  always_comb begin
    logic signed [21:0] x6;
    logic signed [21:0] y6;
    logic signed [36:0] pr_re;
    logic signed [36:0] pr_im;
    logic signed [39:0] t_re;
    logic signed [39:0] t_im;
    logic signed [19:0] re;
    logic signed [19:0] im;
    logic [16:0]        cand;
    x6     = '0;
    y6     = '0;
    pr_re  = '0;
    pr_im  = '0;
    t_re   = '0;
    t_im   = '0;
    re     = '0;
    im     = '0;
    cand   = '0;
    next_s = s;
    next_s.valid = 1'b0;
    // six times the sequence phasor: 2a - b - c + sqrt3 times the quadrature difference
    pr_re = 37'(signed'(phase_im_i[1])) - 37'(signed'(phase_im_i[2]));
    pr_re = pr_re * 37'(signed'({1'b0, `NSOC_SQRT3_Q14}));
    pr_im = 37'(signed'(phase_re_i[2])) - 37'(signed'(phase_re_i[1]));
    pr_im = pr_im * 37'(signed'({1'b0, `NSOC_SQRT3_Q14}));
    x6 = (22'(signed'(phase_re_i[0])) <<< 1) - 22'(signed'(phase_re_i[1])) - 22'(signed'(phase_re_i[2]))
         + 22'(pr_re >>> 14);
    y6 = (22'(signed'(phase_im_i[0])) <<< 1) - 22'(signed'(phase_im_i[1])) - 22'(signed'(phase_im_i[2]))
         + 22'(pr_im >>> 14);
    t_re = 40'(x6) * 40'(signed'({1'b0, `NSOC_SIXTH_Q16}));
    t_im = 40'(y6) * 40'(signed'({1'b0, `NSOC_SIXTH_Q16}));
    re = 20'(t_re >>> 16);
    im = 20'(t_im >>> 16);
    cand = s.root | (17'h1 << s.idx);
    if (!s.busy) begin
      if (phasor_valid_i) begin
        next_s.busy = 1'b1;
        next_s.sq   = 34'(40'(re) * 40'(re)) + 34'(40'(im) * 40'(im));
        next_s.root = '0;
        next_s.idx  = `NSOC_SQRT_TOP;
      end
    end else begin
      // one root bit per clock keeps the multiplier to a single 17 by 17 array
      if (34'(cand) * 34'(cand) <= s.sq) begin
        next_s.root = cand;
      end
      if (s.idx == 5'h0) begin
        next_s.busy  = 1'b0;
        next_s.valid = 1'b1;
        next_s.mag   = (34'(cand) * 34'(cand) <= s.sq) ? ((cand[16]) ? 16'hffff : cand[15:0])
                       : ((s.root[16]) ? 16'hffff : s.root[15:0]);
      end else begin
        next_s.idx = s.idx - 5'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign seq.valid = s.valid;
  assign seq.mag   = s.mag;

  sequence seq_accept;
    phasor_valid_i && !s.busy;
  endsequence

  a_seq_latency : assert property (@(posedge clock_i) disable iff (!rst_n_i)
    seq_accept |-> ##1 !s.valid [*8] ##10 s.valid) else $error("sequence magnitude not ready 18 cycles after phasors");
endmodule

// ### bench/nsoc_phasor_src.sv
// Purpose: phasor stage model, one phasor set every 50 cycles
// Assumes: lvl_i in counts, neg_i picks negative or positive rotation
// Notes:   lines toggle between sets so stale values never look valid
`timescale 1ns/1ps
module nsoc_phasor_src (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] lvl_i,
  input  wire logic        neg_i,
  output logic             valid_o,
  output logic [2:0][15:0] re_o,
  output logic [2:0][15:0] im_o
);
  logic [5:0]  cnt;
  logic [15:0] h;
  logic [15:0] s;
  always_comb begin
    h = lvl_i >> 1;
    s = 16'((32'(lvl_i) * 32'h0000_376d) >> 14);
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 6'h00;
      valid_o <= 1'b0;
      re_o <= '0;
      im_o <= '0;
    end else begin
      cnt <= (cnt == 6'h31) ? 6'h00 : cnt + 6'h01;
      valid_o <= (cnt == 6'h31);
      if (cnt == 6'h31) begin
        re_o <= {-h, -h, lvl_i};
        im_o <= neg_i ? {-s, s, 16'h0000} : {s, -s, 16'h0000};
      end else begin
        re_o <= ~re_o;
        im_o <= ~im_o;
      end
    end
  end
endmodule

// ### bench/tb_nsoc_element.sv
// Purpose: register, start and trip timing checks of the element
// Assumes: TICK_CYC of 100 cycles, so one ms is 100 cycles
// Notes:   inverse runs use the clamped ratio to keep the run short
`timescale 1ns/1ps
module tb_nsoc_element;
  localparam int TICK = 100;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic dis = 1'b0;
  logic [15:0] lvl = 16'h0;
  logic neg = 1'b1;
  logic [31:0] rdata;
  logic pv;
  logic [2:0][15:0] re;
  logic [2:0][15:0] im;
  logic start_o;
  logic trip_o;
  int errors = 0;
  int samples_checked = 0;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [31:0] rv [8] = '{32'h1, 32'h32, 32'h64, 32'h64, 32'h64, 32'h64, 32'h0, 32'h0};

  always #5 clock_i = ~clock_i;

  nsoc_element #(.TICK_CYC(TICK)) u_nsoc_element (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .phasor_valid_i(pv), .phase_re_i(re), .phase_im_i(im), .disable_i(dis),
    .start_o(start_o), .trip_o(trip_o));
  nsoc_phasor_src u_nsoc_phasor_src (.clock_i(clock_i), .rst_n_i(rst_n_i), .lvl_i(lvl),
    .neg_i(neg), .valid_o(pv), .re_o(re), .im_o(im));

  task automatic final_report();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // sample after the edge settles, then realign to the edge for driving
  task automatic chk_out(input logic [31:0] e);
    #1;
    chk({30'h0, trip_o, start_o}, e);
    @(posedge clock_i);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clock_i);
    wr <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
    @(posedge clock_i);
  endtask
  task automatic run_trip(input int lo, input int hi);
    int n;
    n = 0;
    while (start_o !== 1'b1 && n < 200) begin
      @(posedge clock_i);
      n++;
    end
    chk_out(32'h1);
    cyc(lo * TICK);
    chk_out(32'h1);
    n = lo * TICK;
    while (trip_o !== 1'b1 && n < hi * TICK) begin
      @(posedge clock_i);
      n++;
    end
    chk_out(32'h3);
  endtask

  initial begin
    #1000000;
    errors++;
    final_report();
  end

  initial begin
    cyc(5);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    for (int i = 0; i < 8; i++) begin
      rd_chk(ra[i], rv[i]);
    end
    for (int c = 2; c < 13; c++) begin
      wr_reg(8'h00, 32'(c));
      rd_chk(8'h00, 32'(c));
    end
    wr_reg(8'h00, 32'hd);
    rd_chk(8'h00, 32'hc);
    wr_reg(8'h04, 32'h1);
    rd_chk(8'h04, 32'h5);
    wr_reg(8'h04, 32'h12c);
    rd_chk(8'h04, 32'hc8);
    wr_reg(8'h04, 32'h32);
    wr_reg(8'h08, 32'h3);
    wr_reg(8'h00, 32'h1);
    lvl <= 16'h2710;
    run_trip(1, 4);
    rd_chk(8'h18, 32'h3);
    neg <= 1'b0;
    dis <= 1'b1;
    cyc(2);
    chk_out(32'h0);
    dis <= 1'b0;
    wr_reg(8'h08, 32'hea60);
    cyc(300);
    chk_out(32'h0);
    neg <= 1'b1;
    lvl <= 16'h13ec;
    cyc(200);
    chk_out(32'h1);
    lvl <= 16'h1324;
    cyc(200);
    chk_out(32'h1);
    lvl <= 16'h11f8;
    cyc(200);
    chk_out(32'h0);
    lvl <= 16'h1324;
    cyc(200);
    chk_out(32'h0);
    wr_reg(8'h00, 32'h0);
    lvl <= 16'h2710;
    cyc(200);
    chk_out(32'h0);
    lvl <= 16'h0;
    wr_reg(8'h04, 32'h5);
    wr_reg(8'h0c, 32'h0);
    wr_reg(8'h10, 32'h0);
    wr_reg(8'h00, 32'h4);
    lvl <= 16'h4e20;
    run_trip(195, 206);
    lvl <= 16'h0;
    cyc(300);
    wr_reg(8'h14, 32'h78);
    lvl <= 16'h4e20;
    run_trip(234, 247);
    lvl <= 16'h0;
    cyc(300);
    wr_reg(8'h14, 32'h64);
    wr_reg(8'h0c, 32'hfa);
    lvl <= 16'h4e20;
    run_trip(247, 252);
    final_report();
  end
endmodule
